// ---- core/tsrb_bank.sv ----
// Register bank of the temperature sensor, fed by the serial engine and converter
module tsrb_bank
    import tsrb_pkg::*;
(
    input wire logic clk, // 100 MHz clock
    input wire logic sys_rst, // Async reset, active high
    input wire logic ptr_wr, // Pulse: new pointer byte received
    input wire logic [7:0] ptr_in, // Pointer byte
    input wire tsrb_wreq_t wreq, // Data word write
    input wire logic gc_cmd_vld, // Pulse: general-call command byte
    input wire logic [7:0] gc_cmd, // General-call command byte
    input wire logic conv_done, // Pulse: conversion completed
    input wire logic [12:0] conv_val, // Conversion result, 1/16 degC
    output logic [7:0] ptr_q, // Current pointer
    output logic [15:0] rd_data, // Word at current pointer
    output logic [15:0] setup_q // Setup register contents
);
// Contract
// - Result register at 00h holds latest completed conversion, read only.
// - Result is two's complement, LSB one sixteenth degree, both formats.
// - Wide-format flag in setup register 01h picks format; reset 60A0h.
// - After reset the result shows in normal 12-bit format.
// - Normal format: 12 bits in 15:4, low four bits zero.
// - Extended format: 13 bits in 15:3, bits 2:0 read 001.
// - Low threshold at 02h, read-write, resets to 4B00h.
// - High threshold at 03h, read-write, resets to 5000h.
// - Writes to read-only or unmapped pointers change nothing.
// - Last written pointer is kept for repeated reads.
// - General call command 06h restores all registers to reset values.

    // Pointer, register and read-word state
    logic [7:0] ptr_r, ptr_nxt;
    logic [15:0] setup_r, setup_nxt;
    logic [15:0] low_r, low_nxt;
    logic [15:0] high_r, high_nxt;
    logic [12:0] res_r, res_nxt;
    logic [15:0] rd_r, rd_nxt;
    // Decoded requests
    logic gc_rst;
    logic wr_setup;
    logic wr_low;
    logic wr_high;

    // Format a 13-bit result into the visible word
    function automatic logic [15:0] fmt_result(input logic [12:0] v, input logic ext);
        if (ext) begin
            fmt_result = {v, EXT_TAIL};
        end else begin
            fmt_result = {v[11:0], NORM_TAIL};
        end
    endfunction

    // Pointers above the last register answer with a fixed word
    function automatic logic is_unmapped(input logic [7:0] p);
        is_unmapped = (p > PTR_HIGH);
    endfunction

    // Pointers whose writes are acknowledged but dropped
    function automatic logic is_read_only(input logic [7:0] p);
        is_read_only = (p == PTR_RESULT) || is_unmapped(p);
    endfunction

    // General call reset byte; it beats every other request in its cycle
    assign gc_rst = gc_cmd_vld && (gc_cmd == GC_RESET_CMD);

    // Word write strobes; read-only and unmapped pointers match none
    assign wr_setup = wreq.wr && (wreq.ptr == PTR_SETUP);
    assign wr_low = wreq.wr && (wreq.ptr == PTR_LOW);
    assign wr_high = wreq.wr && (wreq.ptr == PTR_HIGH);

    // Pointer next value; general call sends it back to the result
    always_comb begin
        ptr_nxt = ptr_r;
        if (gc_rst) begin
            ptr_nxt = PTR_RESULT;
        end else if (ptr_wr) begin
            ptr_nxt = ptr_in;
        end
    end

    // Pointer register, kept until the next pointer byte
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ptr_r <= PTR_RESULT;
        end else begin
            ptr_r <= ptr_nxt;
        end
    end

    // Setup next value; only writable bits take the new word
    always_comb begin
        setup_nxt = setup_r;
        if (gc_rst) begin
            setup_nxt = RST_SETUP;
        end else if (wr_setup) begin
            setup_nxt = (wreq.data & SETUP_WMASK) | (setup_r & ~SETUP_WMASK);
        end
    end

    // Setup register; reset leaves the normal format selected
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            setup_r <= RST_SETUP;
        end else begin
            setup_r <= setup_nxt;
        end
    end

    // Threshold next values, whole words only
    always_comb begin
        low_nxt = low_r;
        high_nxt = high_r;
        if (gc_rst) begin
            low_nxt = RST_LOW;
            high_nxt = RST_HIGH;
        end else begin
            if (wr_low) begin
                low_nxt = wreq.data;
            end
            if (wr_high) begin
                high_nxt = wreq.data;
            end
        end
    end

    // Threshold registers
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            low_r <= RST_LOW;
            high_r <= RST_HIGH;
        end else begin
            low_r <= low_nxt;
            high_r <= high_nxt;
        end
    end

    // Result next value; each completed conversion replaces it
    always_comb begin
        res_nxt = res_r;
        if (gc_rst) begin
            res_nxt = RST_RESULT[12:0];
        end else if (conv_done) begin
            res_nxt = conv_val;
        end
    end

    // Result register, raw two's complement count in sixteenths of a degree
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            res_r <= RST_RESULT[12:0];
        end else begin
            res_r <= res_nxt;
        end
    end

    // Read word at the next pointer, so it stands in the same cycle as any change
    always_comb begin
        case (ptr_nxt)
            PTR_RESULT: begin
                rd_nxt = fmt_result(res_nxt, setup_nxt[EXT_BIT]);
            end
            PTR_SETUP: begin
                rd_nxt = setup_nxt;
            end
            PTR_LOW: begin
                rd_nxt = low_nxt;
            end
            PTR_HIGH: begin
                rd_nxt = high_nxt;
            end
            default: begin
                rd_nxt = RSVD_READ;
            end
        endcase
    end

    // Read word register; zero result in normal format after reset
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_r <= RST_RESULT;
        end else begin
            rd_r <= rd_nxt;
        end
    end

    // Outputs straight from the registers
    assign ptr_q = ptr_r;
    assign rd_data = rd_r;
    assign setup_q = setup_r;

    // Normal layout: 12 bits on top, zero tail
    AST_RES_FMT_NORM: assert property (@(posedge clk) disable iff (sys_rst)
        (ptr_r == PTR_RESULT && !setup_r[EXT_BIT]) |-> rd_data == {res_r[11:0], 4'h0})
        else $error("normal result format wrong");

    // Extended layout: 13 bits on top, tail reads one
    AST_RES_FMT_EXT: assert property (@(posedge clk) disable iff (sys_rst)
        (ptr_r == PTR_RESULT && setup_r[EXT_BIT]) |-> rd_data == {res_r, 3'h1})
        else $error("extended result format wrong");

    // Sign of the count lands in the top bit in extended format
    AST_RES_SIGN: assert property (@(posedge clk) disable iff (sys_rst)
        (ptr_r == PTR_RESULT && setup_r[EXT_BIT]) |-> rd_data[15] == res_r[12])
        else $error("result sign misplaced");

    // A finished conversion replaces the result
    AST_CONV_UPD: assert property (@(posedge clk) disable iff (sys_rst)
        (conv_done && !gc_rst) |=> res_r == $past(conv_val))
        else $error("result not updated");

    // Result holds between conversions
    AST_RES_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
        (!conv_done && !gc_rst) |=> $stable(res_r))
        else $error("result changed without conversion");

    // Setup write lands in the writable bits
    AST_SETUP_WR: assert property (@(posedge clk) disable iff (sys_rst)
        (wreq.wr && wreq.ptr == PTR_SETUP && !gc_rst)
        |=> (setup_r & SETUP_WMASK) == ($past(wreq.data) & SETUP_WMASK))
        else $error("setup write lost");

    // Fixed setup bits never move
    AST_SETUP_RO: assert property (@(posedge clk) disable iff (sys_rst)
        ((setup_r & ~SETUP_WMASK) == (RST_SETUP & ~SETUP_WMASK)))
        else $error("setup read-only bits changed");

    // Setup holds without a write to it
    AST_SETUP_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
        (!(wreq.wr && wreq.ptr == PTR_SETUP) && !gc_rst) |=> $stable(setup_r))
        else $error("setup changed without write");

    // Setup pointer reads the setup word
    AST_RD_SETUP: assert property (@(posedge clk) disable iff (sys_rst)
        (ptr_r == PTR_SETUP) |-> rd_data == setup_r)
        else $error("setup read value wrong");

    // Low threshold takes a whole word
    AST_LOW_WR: assert property (@(posedge clk) disable iff (sys_rst)
        (wreq.wr && wreq.ptr == PTR_LOW && !gc_rst) |=> low_r == $past(wreq.data))
        else $error("low threshold write lost");

    // Low threshold pointer reads the low threshold
    AST_RD_LOW: assert property (@(posedge clk) disable iff (sys_rst)
        (ptr_r == PTR_LOW) |-> rd_data == low_r)
        else $error("low threshold read value wrong");

    // High threshold takes a whole word
    AST_HIGH_WR: assert property (@(posedge clk) disable iff (sys_rst)
        (wreq.wr && wreq.ptr == PTR_HIGH && !gc_rst) |=> high_r == $past(wreq.data))
        else $error("high threshold write lost");

    // High threshold pointer reads the high threshold
    AST_RD_HIGH: assert property (@(posedge clk) disable iff (sys_rst)
        (ptr_r == PTR_HIGH) |-> rd_data == high_r)
        else $error("high threshold read value wrong");

    // Unmapped pointers read the fixed word
    AST_RSVD_RD: assert property (@(posedge clk) disable iff (sys_rst)
        is_unmapped(ptr_r) |-> rd_data == RSVD_READ)
        else $error("reserved read value wrong");

    // Dropped writes leave setup and both thresholds alone
    AST_RO_WR: assert property (@(posedge clk) disable iff (sys_rst)
        (wreq.wr && is_read_only(wreq.ptr) && !gc_rst)
        |=> $stable(low_r) && $stable(high_r) && $stable(setup_r))
        else $error("ignored write changed state");

    // Thresholds hold without a write
    AST_THR_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
        (!wreq.wr && !gc_rst) |=> $stable(low_r) && $stable(high_r))
        else $error("threshold changed without write");

    // Pointer kept between pointer bytes
    AST_PTR_KEEP: assert property (@(posedge clk) disable iff (sys_rst)
        (!ptr_wr && !gc_rst) |=> $stable(ptr_r))
        else $error("pointer changed without write");

    // Pointer byte loads the pointer
    AST_PTR_LOAD: assert property (@(posedge clk) disable iff (sys_rst)
        (ptr_wr && !gc_rst) |=> ptr_r == $past(ptr_in))
        else $error("pointer byte lost");

    // General call restores the writable registers
    AST_GC_RST: assert property (@(posedge clk) disable iff (sys_rst)
        gc_rst |=> setup_r == RST_SETUP && low_r == RST_LOW && high_r == RST_HIGH)
        else $error("general call reset failed");

    // General call restores pointer and result
    AST_GC_PTR: assert property (@(posedge clk) disable iff (sys_rst)
        gc_rst |=> ptr_r == PTR_RESULT && res_r == RST_RESULT[12:0])
        else $error("general call left pointer or result");

    // After general call the result shows in normal format
    AST_GC_FMT: assert property (@(posedge clk) disable iff (sys_rst)
        gc_rst |=> rd_data == {RST_RESULT[11:0], 4'h0})
        else $error("general call left wrong format");

    // Extended result on view
    COV_EXT: cover property (@(posedge clk) setup_r[EXT_BIT] && ptr_r == PTR_RESULT);
    // Negative result on view
    COV_NEG: cover property (@(posedge clk) ptr_r == PTR_RESULT && res_r[12]);
    // General call reset taken
    COV_GC: cover property (@(posedge clk) gc_rst);
    // Write aimed at the result register
    COV_RO_WR: cover property (@(posedge clk) wreq.wr && wreq.ptr == PTR_RESULT);
    // Write aimed at unmapped space
    COV_RSVD_WR: cover property (@(posedge clk) wreq.wr && is_unmapped(wreq.ptr));
endmodule

// ---- shared/tsrb_pkg.sv ----
// Package for the temperature sensor register bank: pointers, layouts, reset values
package tsrb_pkg;
    localparam logic [7:0] PTR_RESULT = 8'h00;
    localparam logic [7:0] PTR_SETUP = 8'h01;
    localparam logic [7:0] PTR_LOW = 8'h02;
    localparam logic [7:0] PTR_HIGH = 8'h03;
    localparam logic [15:0] RST_SETUP = 16'h60a0;
    localparam logic [15:0] RST_LOW = 16'h4b00;
    localparam logic [15:0] RST_HIGH = 16'h5000;
    localparam logic [15:0] RST_RESULT = 16'h0000;
    localparam logic [15:0] RSVD_READ = 16'h0000;
    // Writable bits of the setup word: 15, 12:6, 4
    localparam logic [15:0] SETUP_WMASK = 16'h9fd0;
    localparam int EXT_BIT = 4;
    localparam logic [7:0] GC_RESET_CMD = 8'h06;
    localparam logic [3:0] NORM_TAIL = 4'h0;
    localparam logic [2:0] EXT_TAIL = 3'h1;

    // Register write request from the serial engine
    typedef struct packed {
        logic wr;
        logic [7:0] ptr;
        logic [15:0] data;
    } tsrb_wreq_t;
endpackage

// ---- tb/tsrb_bank_test.sv ----
// Self-checking bench for the temperature register bank
module tsrb_bank_test import tsrb_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, sys_rst = 1, ptr_wr, gc_cmd_vld, conv_done = 0;
    logic [7:0] ptr_in, gc_cmd, ptr_q;
    logic [12:0] conv_val = '0;
    logic [15:0] rd_data, setup_q;
    tsrb_wreq_t wreq;
    int errors = 0, n_checks = 0;
    // Clock
    always #5 clk = ~clk;
    tsrb_bank i_tsrb_bank(.clk(clk), .sys_rst(sys_rst), .ptr_wr(ptr_wr), .ptr_in(ptr_in),
        .wreq(wreq), .gc_cmd_vld(gc_cmd_vld), .gc_cmd(gc_cmd), .conv_done(conv_done),
        .conv_val(conv_val), .ptr_q(ptr_q), .rd_data(rd_data), .setup_q(setup_q));
    tsrb_host i_tsrb_host(.clk(clk), .ptr_wr(ptr_wr), .ptr_in(ptr_in), .wreq(wreq),
        .gc_cmd_vld(gc_cmd_vld), .gc_cmd(gc_cmd));
    // Comparison and verdict
    task automatic chk(input string nm, input logic [15:0] got, exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic rd(input logic [7:0] p, input logic [15:0] exp);
        i_tsrb_host.point(p);
        chk($sformatf("word at %h", p), rd_data, exp);
    endtask
    task automatic conv(input logic [12:0] v);
        @(negedge clk) {conv_done, conv_val} = {1'b1, v};
        @(negedge clk) {conv_done, conv_val} = {1'b0, ~v};
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Reset values, power-up format and reserved space
    task automatic t_reset;
        rd(PTR_SETUP, RST_SETUP);
        rd(PTR_LOW, RST_LOW);
        rd(PTR_HIGH, RST_HIGH);
        rd(PTR_RESULT, 16'h0000);
        rd(8'h04, RSVD_READ);
        rd(8'hff, RSVD_READ);
        $display("test reset done");
    endtask
    // Writes, read-only and unmapped targets
    task automatic t_regs;
        i_tsrb_host.wr(PTR_LOW, 16'h1234);
        i_tsrb_host.wr(PTR_HIGH, 16'habcd);
        i_tsrb_host.wr(PTR_SETUP, 16'hffff);
        i_tsrb_host.wr(PTR_RESULT, 16'hffff);
        i_tsrb_host.wr(8'h07, 16'hffff);
        rd(PTR_LOW, 16'h1234);
        rd(PTR_HIGH, 16'habcd);
        chk("setup", setup_q, 16'hfff0);
        // Extended flag now set: zero result reads with the 001 tail
        rd(PTR_RESULT, 16'h0001);
        rd(8'h07, RSVD_READ);
        $display("test regs done");
    endtask
    // Result formats with the pointer left on the result
    task automatic t_fmt;
        i_tsrb_host.wr(PTR_SETUP, RST_SETUP);
        i_tsrb_host.point(PTR_RESULT);
        conv(13'h0191);
        chk("normal", rd_data, 16'h1910);
        conv(13'h1ff0);
        chk("negative", rd_data, 16'hff00);
        i_tsrb_host.wr(PTR_SETUP, 16'h60b0);
        chk("extended", rd_data, 16'hff81);
        conv(13'h0191);
        chk("refresh", rd_data, 16'h0c89);
        chk("pointer", {8'h00, ptr_q}, 16'h0000);
        $display("test format done");
    endtask
    // General call: other byte ignored, reset byte restores
    task automatic t_gc;
        i_tsrb_host.gcall(8'h05);
        chk("gc other", setup_q, 16'h60b0);
        i_tsrb_host.point(PTR_LOW);
        i_tsrb_host.gcall(GC_RESET_CMD);
        chk("gc setup", setup_q, RST_SETUP);
        chk("gc pointer", {8'h00, ptr_q}, 16'h0000);
        chk("gc result", rd_data, 16'h0000);
        rd(PTR_LOW, RST_LOW);
        rd(PTR_HIGH, RST_HIGH);
        $display("test general call done");
    endtask
    // Reset in mid-run restores the power-up state
    task automatic t_rst;
        i_tsrb_host.wr(PTR_HIGH, 16'h1111);
        i_tsrb_host.wr(PTR_SETUP, 16'h60b0);
        i_tsrb_host.point(PTR_HIGH);
        chk("high before reset", rd_data, 16'h1111);
        @(negedge clk) sys_rst = 1;
        repeat (2) @(negedge clk);
        sys_rst = 0;
        chk("reset setup", setup_q, RST_SETUP);
        chk("reset pointer", {8'h00, ptr_q}, 16'h0000);
        chk("reset word", rd_data, 16'h0000);
        rd(PTR_HIGH, RST_HIGH);
        $display("test mid-run reset done");
    endtask
    // Main sequence
    initial begin
        repeat (20) @(negedge clk);
        sys_rst = 0;
        t_reset();
        t_regs();
        t_fmt();
        t_gc();
        t_rst();
        stop_test();
    end
    // Watchdog
    initial begin
        #100000;
        errors++;
        stop_test();
    end
endmodule

// ---- tb/tsrb_host.sv ----
// Bus controller model driving pointer, word and general-call strobes
module tsrb_host
    import tsrb_pkg::*;
(
    input wire logic clk, // Bank clock
    output logic ptr_wr, // Pointer strobe
    output logic [7:0] ptr_in, // Pointer byte
    output tsrb_wreq_t wreq, // Word write
    output logic gc_cmd_vld, // General-call strobe
    output logic [7:0] gc_cmd // General-call byte
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle bus
    initial begin
        {ptr_wr, ptr_in, wreq, gc_cmd_vld, gc_cmd} = '0;
    end
    // Pointer byte after the address byte; released lines show inverse
    task automatic point(input logic [7:0] p);
        @(negedge clk) {ptr_wr, ptr_in} = {1'b1, p};
        @(negedge clk) {ptr_wr, ptr_in} = {1'b0, ~p};
    endtask
    // Whole data word to a pointer
    task automatic wr(input logic [7:0] p, input logic [15:0] d);
        @(negedge clk) wreq = '{1'b1, p, d};
        @(negedge clk) wreq = '{1'b0, ~p, ~d};
    endtask
    // General-call command byte
    task automatic gcall(input logic [7:0] c);
        @(negedge clk) {gc_cmd_vld, gc_cmd} = {1'b1, c};
        @(negedge clk) {gc_cmd_vld, gc_cmd} = {1'b0, ~c};
    endtask
endmodule
